// file: design/acr_pkg.sv
// Package for the converter control register slice
//
// Contract
// RULE1: Sleep enable bit 4 powers down blocks named by the chosen sleep mask.
// RULE2: Mask choice bit 5 picks mask one when 0, mask two when 1.
// RULE3: Software writes all four performance bits together; top bit sits in 56h bit 2.
// RULE4: Routing bit 7 drives channel B overrange flag onto the readback pin.
// RULE5: One 8-bit threshold, reset E3h, serves both channels jointly.
// RULE6: Main digital page values apply only after commit bit pulses 0-1-0.
// RULE7: Software pulses commit after power-up and after each configuration round.
// RULE8: Filter mode is bits 4 and 2-0, low part resets 2h, gated by enable.
// RULE9: Enable 0 or mode 1010 gives 2X low-pass; 1110 gives 2X high-pass.
// RULE10: Software writes zero to reserved bits and one to routing bit 5.
package acr_pkg;

  // ==========================================================
  // Register offsets (word index, byte address is four times)
  localparam logic [7:0] ACR_IDX_COMMIT    = 8'h00;
  localparam logic [7:0] ACR_IDX_DECFIL    = 8'h41;
  localparam logic [7:0] ACR_IDX_SLEEP     = 8'h55;
  localparam logic [7:0] ACR_IDX_PERF      = 8'h56;
  localparam logic [7:0] ACR_IDX_ROUTE     = 8'h59;
  localparam logic [7:0] ACR_IDX_THRESH    = 8'h5F;
  localparam logic [7:0] ACR_IDX_CHOICE    = 8'h60;
  localparam logic [7:0] ACR_IDX_DECEN     = 8'h61;
  localparam logic [7:0] ACR_IDX_INT_STAT  = 8'h62;
  localparam logic [7:0] ACR_IDX_INT_MASK  = 8'h63;
  localparam logic [7:0] ACR_IDX_STATUS    = 8'h64;

  // ==========================================================
  // Field positions
  localparam int ACR_BIT_COMMIT   = 0;
  localparam int ACR_BIT_SLEEP_EN = 4;
  localparam int ACR_BIT_CHOICE   = 5;
  localparam int ACR_BIT_PERF_TOP = 2;
  localparam int ACR_BIT_ROUTE    = 7;
  localparam int ACR_BIT_FORCE1   = 5;
  localparam int ACR_BIT_MODE_HI  = 4;
  localparam int ACR_BIT_DECEN    = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ACR_RST_DECFIL = 8'h02;
  localparam logic [7:0] ACR_RST_THRESH = 8'hE3;
  localparam logic [7:0] ACR_RST_ZERO   = 8'h00;

  // ==========================================================
  // Filter mode codes
  localparam logic [3:0] ACR_MODE_LOWPASS  = 4'hA;
  localparam logic [3:0] ACR_MODE_HIGHPASS = 4'hE;

  // Interrupt status bit positions
  localparam int ACR_IRQ_COMMIT  = 0;
  localparam int ACR_IRQ_BADMODE = 1;
  localparam int ACR_IRQ_W       = 2;

  typedef enum logic [1:0] {
    ACR_FILT_LOWPASS,
    ACR_FILT_HIGHPASS,
    ACR_FILT_UNUSED
  } acr_filt_t;

  // Settings applied on commit
  typedef struct packed {
    logic [3:0] mode;
    logic       dec_en;
  } acr_digital_t;

endpackage

// file: design/acr_commit_detect.sv
// Detects the 0-1-0 pulse on the commit bit
`timescale 1ns/1ps
module acr_commit_detect
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Commit bit level
  input  wire logic level_i,
  // One-cycle apply strobe on falling edge
  output logic      apply_o
);

  logic seen_high_r;

  // RULE6: apply on fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_high_r <= 1'b0;
      apply_o     <= 1'b0;
    end else begin
      apply_o     <= seen_high_r & ~level_i;
      seen_high_r <= level_i;
    end
  end

endmodule

// file: design/acr_filter_decode.sv
// Decodes the applied decimation filter mode
`timescale 1ns/1ps
module acr_filter_decode
  import acr_pkg::*;
(
  // Applied settings
  input  wire acr_digital_t cfg_i,
  // Decoded mode
  output acr_filt_t         filt_o
);

  // RULE9: mode decode
  always_comb begin
    if (!cfg_i.dec_en) begin
      filt_o = ACR_FILT_LOWPASS;
    end else if (cfg_i.mode == ACR_MODE_LOWPASS) begin
      filt_o = ACR_FILT_LOWPASS;
    end else if (cfg_i.mode == ACR_MODE_HIGHPASS) begin
      filt_o = ACR_FILT_HIGHPASS;
    end else begin
      filt_o = ACR_FILT_UNUSED;
    end
  end

endmodule

// file: design/acr_regs.sv
// Control register slice with Wishbone slave
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Converter side
  input  wire logic        chb_overrange_i,
  input  wire logic        readback_data_i,
  input  wire logic [1:0]  sleep_mask_one_i,
  input  wire logic [1:0]  sleep_mask_two_i,
  output logic [1:0]       sleep_blocks_o,
  output logic             serial_readback_pin_o,
  output logic [7:0]       overrange_threshold_o,
  output logic [3:0]       performance_setting_top_o,
  output logic             highpass_o,
  output logic             unused_mode_o,
  output logic             irq_o
);

  // ==========================================================
  // Registers
  logic [7:0]    commit_r;
  logic [7:0]    decfil_r;
  logic [7:0]    sleep_r;
  logic [7:0]    perf_r;
  logic [7:0]    route_r;
  logic [7:0]    thresh_r;
  logic          choice_r;
  logic          decen_r;
  logic [ACR_IRQ_W-1:0] int_stat_r;
  logic [ACR_IRQ_W-1:0] int_mask_r;
  acr_digital_t  applied_r;
  logic [2:0]    ovr_sync_r;
  logic          ovr_q_r;
  logic          applied_evt_r;

  logic          req;
  logic          wr;
  logic [7:0]    idx;
  logic [7:0]    rd_byte;
  logic          apply;
  acr_filt_t     filt;
  logic [ACR_IRQ_W-1:0] events;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr  = req & we_i & sel_i[0];
  assign idx = adr_i[9:2];

  // ==========================================================
  // Bus ack, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ==========================================================
  // Software writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      commit_r <= ACR_RST_ZERO;
      decfil_r <= ACR_RST_DECFIL;
      sleep_r  <= ACR_RST_ZERO;
      perf_r   <= ACR_RST_ZERO;
      route_r  <= ACR_RST_ZERO;
      thresh_r <= ACR_RST_THRESH;
      choice_r <= 1'b0;
      decen_r  <= 1'b0;
      int_mask_r <= '0;
    end else if (wr) begin
      unique case (idx)
        ACR_IDX_COMMIT:   commit_r <= dat_i[7:0];
        ACR_IDX_DECFIL:   decfil_r <= dat_i[7:0];
        ACR_IDX_SLEEP:    sleep_r  <= dat_i[7:0];
        // RULE3: top performance bit
        ACR_IDX_PERF:     perf_r   <= dat_i[7:0];
        ACR_IDX_ROUTE:    route_r  <= dat_i[7:0];
        // RULE5: shared threshold
        ACR_IDX_THRESH:   thresh_r <= dat_i[7:0];
        ACR_IDX_CHOICE:   choice_r <= dat_i[ACR_BIT_CHOICE];
        ACR_IDX_DECEN:    decen_r  <= dat_i[ACR_BIT_DECEN];
        ACR_IDX_INT_MASK: int_mask_r <= dat_i[ACR_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Commit of main digital page settings
  acr_commit_detect u_commit (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (commit_r[ACR_BIT_COMMIT]),
    .apply_o (apply)
  );

  // RULE6: hold until commit
  // RULE8: mode bits 4 and 2-0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_r.mode   <= {1'b0, ACR_RST_DECFIL[2:0]};
      applied_r.dec_en <= 1'b0;
    end else if (apply) begin
      applied_r.mode   <= {decfil_r[ACR_BIT_MODE_HI], decfil_r[2:0]};
      applied_r.dec_en <= decen_r;
    end
  end

  acr_filter_decode u_decode (
    .cfg_i  (applied_r),
    .filt_o (filt)
  );

  // ==========================================================
  // Overrange flag synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_sync_r <= '0;
      ovr_q_r    <= 1'b0;
    end else begin
      ovr_sync_r <= {ovr_sync_r[1:0], chb_overrange_i};
      if (ovr_sync_r[1] == ovr_sync_r[2]) begin
        ovr_q_r <= ovr_sync_r[2];
      end
    end
  end

  // ==========================================================
  // Converter side outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_blocks_o            <= '0;
      serial_readback_pin_o     <= 1'b0;
      overrange_threshold_o     <= ACR_RST_THRESH;
      performance_setting_top_o <= '0;
      highpass_o                <= 1'b0;
      unused_mode_o             <= 1'b0;
    end else begin
      // RULE1: sleep enable
      // RULE2: mask choice
      if (sleep_r[ACR_BIT_SLEEP_EN]) begin
        sleep_blocks_o <= choice_r ? sleep_mask_two_i : sleep_mask_one_i;
      end else begin
        sleep_blocks_o <= '0;
      end
      // RULE4: overrange routing
      serial_readback_pin_o <= route_r[ACR_BIT_ROUTE] ? ovr_q_r : readback_data_i;
      // RULE5: joint threshold
      overrange_threshold_o <= thresh_r;
      performance_setting_top_o <= {perf_r[ACR_BIT_PERF_TOP], 3'h0};
      // RULE9: filter select
      highpass_o    <= (filt == ACR_FILT_HIGHPASS);
      unused_mode_o <= (filt == ACR_FILT_UNUSED);
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  // Events judge the settings just applied, so they wait one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_evt_r <= 1'b0;
    end else begin
      applied_evt_r <= apply;
    end
  end

  assign events = {(applied_evt_r && filt == ACR_FILT_UNUSED), applied_evt_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~((wr && idx == ACR_IDX_INT_STAT) ? dat_i[ACR_IRQ_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_stat_r & int_mask_r);
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    unique case (idx)
      ACR_IDX_COMMIT:   rd_byte = commit_r & 8'h01;
      ACR_IDX_DECFIL:   rd_byte = decfil_r & 8'h17;
      ACR_IDX_SLEEP:    rd_byte = sleep_r & 8'h10;
      ACR_IDX_ROUTE:    rd_byte = route_r & 8'h20;
      ACR_IDX_THRESH:   rd_byte = thresh_r;
      ACR_IDX_CHOICE:   rd_byte = {2'h0, choice_r, 5'h00};
      ACR_IDX_DECEN:    rd_byte = {7'h00, decen_r};
      ACR_IDX_INT_STAT: rd_byte = {6'h00, int_stat_r};
      ACR_IDX_INT_MASK: rd_byte = {6'h00, int_mask_r};
      ACR_IDX_STATUS:   rd_byte = {3'h0, applied_r.mode, applied_r.dec_en};
      default:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !we_i) begin
      dat_o <= {24'h000000, rd_byte};
    end else begin
      dat_o <= '0;
    end
  end

endmodule

// file: dv/acr_regs_properties.sv
// Port assertions for the register slice
`timescale 1ns/1ps
module acr_regs_properties
  import acr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [1:0]  sleep_mask_one_i,
  input wire logic [1:0]  sleep_mask_two_i,
  input wire logic [1:0]  sleep_blocks_o,
  input wire logic [7:0]  overrange_threshold_o,
  input wire logic        highpass_o,
  input wire logic        unused_mode_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       wr   = cyc_i && stb_i && we_i && sel_i[0];
  wire       wthr = wr && adr_i[9:2] == ACR_IDX_THRESH;
  wire       wend = wr && adr_i[9:2] == ACR_IDX_COMMIT && !dat_i[ACR_BIT_COMMIT];
  logic [5:0] end_q;
  logic [2:0] thr_q;
  // ==========================================
  // Recent write history
  always_ff @(posedge clk_i) begin
    end_q <= {end_q[4:0], wend};
    thr_q <= {thr_q[1:0], wthr};
  end
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ans; ack_o ##1 !ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
  property p_rst; $fell(rst_i) |-> overrange_threshold_o == ACR_RST_THRESH && sleep_blocks_o == 2'h0 && !irq_o;
  endproperty
  property p_thr; $changed(overrange_threshold_o) |-> |{thr_q, wthr}; endproperty
  property p_slp; sleep_blocks_o != 2'h0 |->
    sleep_blocks_o == $past(sleep_mask_one_i) || sleep_blocks_o == $past(sleep_mask_two_i); endproperty
  property p_excl; !(highpass_o && unused_mode_o); endproperty
  property p_cmt; $changed(highpass_o) || $changed(unused_mode_o) |-> |end_q; endproperty
  property p_hold; !(|end_q) && !wend |=> $stable(highpass_o); endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_idle: assert property (p_idle) else $error("read data outside ack");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_thr: assert property (p_thr) else $error("threshold moved unwritten");
  a_slp: assert property (p_slp) else $error("sleep not a mask");
  a_excl: assert property (p_excl) else $error("two filter modes");
  a_cmt: assert property (p_cmt) else $error("mode applied without commit");
  a_hold: assert property (p_hold) else $error("highpass moved");
endmodule
bind acr_regs acr_regs_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .sleep_mask_one_i(sleep_mask_one_i), .sleep_mask_two_i(sleep_mask_two_i), .sleep_blocks_o(sleep_blocks_o),
  .overrange_threshold_o(overrange_threshold_o), .highpass_o(highpass_o), .unused_mode_o(unused_mode_o),
  .irq_o(irq_o));

// file: dv/test_acr_regs.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
module test_acr_regs
  import acr_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        chb_i = 0, rbd_i = 0, ack_o, pin_o, hp_o, un_o, irq_o;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'hF, perf_o;
  logic [31:0] dat_i = 32'h0, dat_o, q[$];
  logic [1:0]  m1 = 2'h1, m2 = 2'h2, slp_o, pe, fe[4] = '{2'h0, 2'h0, 2'h2, 2'h1};
  logic [7:0]  thr_o, t, fm[4] = '{8'h16, 8'h12, 8'h16, 8'h03};
  logic        de[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  int          n_mismatch = 0, checks = 0, cyc_n = 0;
  always #25 clk_i = ~clk_i;
  acr_regs i_acr_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chb_overrange_i(chb_i),
    .readback_data_i(rbd_i), .sleep_mask_one_i(m1), .sleep_mask_two_i(m2), .sleep_blocks_o(slp_o),
    .serial_readback_pin_o(pin_o), .overrange_threshold_o(thr_o), .performance_setting_top_o(perf_o),
    .highpass_o(hp_o), .unused_mode_o(un_o), .irq_o(irq_o));
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {a, 2'h0};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    wb(0, a, 8'h00);
  endtask
  task wt;
    repeat (6) @(posedge clk_i);
  endtask
  // ==========================================
  // Read data monitor and timeout
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 4000) begin
      n_mismatch++;
      summarize;
    end else if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) begin
      chk("rdata", q.pop_front(), dat_o);
    end
  end
  initial begin
    void'($urandom(50));
    t = 8'($urandom);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, ACR_IDX_COMMIT, 8'h01);
    wb(1, ACR_IDX_COMMIT, 8'h00);
    rd(ACR_IDX_COMMIT, 8'h00);
    rd(ACR_IDX_DECFIL, ACR_RST_DECFIL);
    rd(ACR_IDX_SLEEP, 8'h00);
    rd(ACR_IDX_PERF, 8'h00);
    rd(ACR_IDX_THRESH, ACR_RST_THRESH);
    rd(8'h7F, 8'h00);
    wb(1, ACR_IDX_THRESH, t);
    rd(ACR_IDX_THRESH, t);
    wt;
    chk("thr", t, thr_o);
    wb(1, ACR_IDX_SLEEP, 8'h10);
    wt;
    chk("slp1", m1, slp_o);
    wb(1, ACR_IDX_CHOICE, 8'h20);
    wt;
    chk("slp2", m2, slp_o);
    wb(1, ACR_IDX_SLEEP, 8'h00);
    wt;
    chk("slp0", 0, slp_o);
    wb(1, ACR_IDX_PERF, 8'h04);
    wt;
    chk("perf", 4'h8, perf_o);
    wb(1, ACR_IDX_ROUTE, 8'hA0);
    chb_i <= 1;
    wt;
    chk("pin1", 1, pin_o);
    wb(1, ACR_IDX_ROUTE, 8'h20);
    chb_i <= 0;
    rbd_i <= 1;
    wt;
    chk("pin0", 1, pin_o);
    rd(ACR_IDX_ROUTE, 8'h20);
    pe = 2'h0;
    for (int i = 0; i < 4; i++) begin
      wb(1, ACR_IDX_DECFIL, fm[i]);
      wb(1, ACR_IDX_DECEN, {7'h0, de[i]});
      wt;
      chk("hold", pe, {hp_o, un_o});
      wb(1, ACR_IDX_COMMIT, 8'h01);
      wb(1, ACR_IDX_COMMIT, 8'h00);
      wt;
      chk("mode", fe[i], {hp_o, un_o});
      rd(ACR_IDX_STATUS, {3'h0, fm[i][4], fm[i][2:0], de[i]});
      pe = fe[i];
    end
    chk("irq", 0, irq_o);
    wb(1, ACR_IDX_INT_MASK, 8'h03);
    wt;
    chk("irqm", 1, irq_o);
    rd(ACR_IDX_INT_STAT, 8'h03);
    wb(1, ACR_IDX_INT_STAT, 8'h03);
    wt;
    chk("irqc", 0, irq_o);
    rd(ACR_IDX_INT_STAT, 8'h00);
    wb(1, ACR_IDX_INT_MASK, 8'h00);
    summarize;
  end
endmodule
